// *** hw/err_route_pkg.sv ***
// Constants for the error message routing block
package err_route_pkg;
	localparam int REG_W = 16;
	localparam int ADDR_W = 8;
	localparam logic [7:0] SYSERR_EN_OFFSET = 8'hCA;
	localparam logic [7:0] MGMT_EN_OFFSET = 8'hCC;
	localparam logic [15:0] SYSERR_EN_RESET = 16'h0000;
	localparam logic [15:0] MGMT_EN_RESET = 16'h0000;
	localparam logic [15:0] SYSERR_EN_WMASK = 16'h0A03;
	localparam logic [15:0] MGMT_EN_WMASK = 16'h0803;
	localparam logic [15:0] STATUS_MASK = 16'h0A03;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam int THERMAL_BIT = 11;
	localparam int LOCK_BIT = 9;
	localparam int MULTIBIT_BIT = 1;
	localparam int SINGLEBIT_BIT = 0;
	localparam int NUM_SRC = 4;
	localparam logic [1:0] MSG_SYSERR = 2'h1;
	localparam logic [1:0] MSG_MGMT = 2'h2;
	localparam logic [1:0] MSG_NONE = 2'h0;
endpackage : err_route_pkg

// *** hw/error_message_routing.sv ***
// Error status capture and system-error / management-interrupt message routing
`timescale 1ns/10ps
`default_nettype none
//Function
// R1 - Errors leave as link messages, no pin
// R2 - Enabled flag set sends system-error message
// R3 - Command-register global enable gates system-error messages
// R4 - Bit 11 enables thermal system-error message
// R5 - Software avoids both thermal reports at once
// R6 - Bit 9 enables non-DRAM lock system-error
// R7 - Bit 1 enables multibit ECC system-error
// R8 - Bit 0 enables single-bit ECC system-error
// R9 - Without ECC, software clears ECC enables
// R10 - Mgmt bit 11 enables thermal interrupt message
// R11 - One thermal trip gives one message
// R12 - Mgmt bit 1 enables multibit ECC interrupt
// R13 - Mgmt bit 0 enables single-bit ECC interrupt
// R14 - Software enables one report type only
// R15 - Enables reset zero, reserved bits read zero
// R16 - Mgmt reserved bits read zero, ignore writes
// R17 - Thermal flag set blocks further thermal messages
// R18 - Flags sticky, write-one clear, power-good reset
// R19 - Message once per flag rising edge
module error_message_routing
	import err_route_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic pwrgood_rst_in,
	input wire logic ce_in,
	input wire logic cfg_wr_in,
	input wire logic cfg_rd_in,
	input wire logic [ADDR_W-1:0] cfg_addr_in,
	input wire logic [1:0] cfg_be_in,
	input wire logic [REG_W-1:0] cfg_wdata_in,
	output logic [REG_W-1:0] cfg_rdata_out,
	input wire logic status_clr_in,
	input wire logic [REG_W-1:0] status_clr_data_in,
	output logic [REG_W-1:0] error_status_flags_out,
	input wire logic syserr_global_en_in,
	input wire logic thermal_trip_in,
	input wire logic nondram_lock_in,
	input wire logic multibit_ecc_in,
	input wire logic singlebit_ecc_in,
	output logic link_valid_out,
	output logic [1:0] link_kind_out,
	input wire logic link_ready_in
);
	logic [REG_W-1:0] system_error_report_enable_ff;
	logic [REG_W-1:0] nxt_syserr_en;
	logic [REG_W-1:0] mgmt_interrupt_report_enable_ff;
	logic [REG_W-1:0] nxt_mgmt_en;
	logic [REG_W-1:0] status_ff;
	logic [REG_W-1:0] nxt_status;
	logic [REG_W-1:0] rdata_ff;
	logic [REG_W-1:0] nxt_rdata;
	logic [NUM_SRC-1:0] pend_syserr_ff;
	logic [NUM_SRC-1:0] nxt_pend_syserr;
	logic [NUM_SRC-1:0] pend_mgmt_ff;
	logic [NUM_SRC-1:0] nxt_pend_mgmt;
	logic [REG_W-1:0] evt;
	logic [REG_W-1:0] wmask;
	logic [REG_W-1:0] rise;
	logic [NUM_SRC-1:0] src_rise;
	logic [NUM_SRC-1:0] src_syserr_en;
	logic [NUM_SRC-1:0] src_mgmt_en;
	logic thermal_ok;
	logic take;
	logic take_mgmt;
	msg_req_if req ();

	localparam int SRC_BIT [NUM_SRC] = '{SINGLEBIT_BIT, MULTIBIT_BIT, LOCK_BIT, THERMAL_BIT};

	assign error_status_flags_out = status_ff;
	assign cfg_rdata_out = rdata_ff;
	assign wmask = {{8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};

	// A thermal trip is captured only when some report is enabled and the flag is clear
	assign thermal_ok = !status_ff[THERMAL_BIT] &&
		(system_error_report_enable_ff[THERMAL_BIT] ||
		mgmt_interrupt_report_enable_ff[THERMAL_BIT]); // [R17]

	always_comb
	begin
		evt = '0;
		evt[THERMAL_BIT] = thermal_trip_in && thermal_ok; // [R17]
		evt[LOCK_BIT] = nondram_lock_in;
		evt[MULTIBIT_BIT] = multibit_ecc_in;
		evt[SINGLEBIT_BIT] = singlebit_ecc_in;
		rise = evt & ~status_ff; // [R19]
	end

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : gen_src
			assign src_rise[g] = rise[SRC_BIT[g]];
			assign src_syserr_en[g] = system_error_report_enable_ff[SRC_BIT[g]]; // [R4] [R6] [R7] [R8]
			assign src_mgmt_en[g] = (SRC_BIT[g] != LOCK_BIT) &&
				mgmt_interrupt_report_enable_ff[SRC_BIT[g]]; // [R10] [R12] [R13]
		end
	endgenerate

	// A write-one clear wins over a repeat event on a set flag, so that event is not recorded
	always_comb
	begin
		nxt_status = (status_ff & ~(status_clr_in ? status_clr_data_in : '0)) | rise; // [R18]
		nxt_status = nxt_status & STATUS_MASK;
	end

	always_comb
	begin
		nxt_syserr_en = system_error_report_enable_ff;
		nxt_mgmt_en = mgmt_interrupt_report_enable_ff;
		nxt_rdata = '0;
		if (cfg_wr_in && cfg_addr_in == SYSERR_EN_OFFSET)
			nxt_syserr_en = ((system_error_report_enable_ff & ~wmask) |
				(cfg_wdata_in & wmask)) & SYSERR_EN_WMASK; // [R15]
		if (cfg_wr_in && cfg_addr_in == MGMT_EN_OFFSET)
			nxt_mgmt_en = ((mgmt_interrupt_report_enable_ff & ~wmask) |
				(cfg_wdata_in & wmask)) & MGMT_EN_WMASK; // [R16]
		if (cfg_rd_in && cfg_addr_in == SYSERR_EN_OFFSET)
			nxt_rdata = system_error_report_enable_ff & SYSERR_EN_WMASK; // [R15]
		else if (cfg_rd_in && cfg_addr_in == MGMT_EN_OFFSET)
			nxt_rdata = mgmt_interrupt_report_enable_ff & MGMT_EN_WMASK; // [R16]
	end

	// Pending bits queue messages since the link accepts one at a time.
	// A thermal source sends system-error first and drops the other, so one trip is one message.
	assign take = req.valid && req.ready;
	assign take_mgmt = take && (req.kind == MSG_MGMT);

	always_comb
	begin
		nxt_pend_syserr = pend_syserr_ff;
		nxt_pend_mgmt = pend_mgmt_ff;
		if (take && !take_mgmt)
			nxt_pend_syserr = pend_syserr_ff & (pend_syserr_ff - 1'b1);
		if (take_mgmt)
			nxt_pend_mgmt = pend_mgmt_ff & (pend_mgmt_ff - 1'b1);
		nxt_pend_syserr = nxt_pend_syserr |
			(src_rise & src_syserr_en & {NUM_SRC{syserr_global_en_in}}); // [R2] [R3]
		nxt_pend_mgmt = nxt_pend_mgmt | (src_rise & src_mgmt_en &
			~(src_syserr_en & {NUM_SRC{syserr_global_en_in}} &
			(NUM_SRC'(1) << (NUM_SRC - 1)))); // [R11]
	end

	assign req.valid = (|pend_syserr_ff) || (|pend_mgmt_ff);
	assign req.kind = (|pend_syserr_ff) ? MSG_SYSERR : MSG_MGMT; // [R1]

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			system_error_report_enable_ff <= SYSERR_EN_RESET; // [R15]
			mgmt_interrupt_report_enable_ff <= MGMT_EN_RESET;
			rdata_ff <= '0;
			pend_syserr_ff <= '0;
			pend_mgmt_ff <= '0;
		end
		else if (ce_in)
		begin
			system_error_report_enable_ff <= nxt_syserr_en;
			mgmt_interrupt_report_enable_ff <= nxt_mgmt_en;
			rdata_ff <= nxt_rdata;
			pend_syserr_ff <= nxt_pend_syserr;
			pend_mgmt_ff <= nxt_pend_mgmt;
		end
	end

	// Flags survive ordinary reset; only power-good reset or a write-one clear clears them
	always_ff @(posedge clk_in)
	begin
		if (pwrgood_rst_in)
			status_ff <= STATUS_RESET; // [R18]
		else if (ce_in)
			status_ff <= nxt_status;
	end

	msg_sender u_sender (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.req(req),
		.link_valid_out(link_valid_out),
		.link_kind_out(link_kind_out),
		.link_ready_in(link_ready_in)
	);

	AST_SYSERR_QUEUED: assert property (@(posedge clk_in) disable iff (srst_in)
		(ce_in && singlebit_ecc_in && !status_ff[SINGLEBIT_BIT] && syserr_global_en_in &&
		system_error_report_enable_ff[SINGLEBIT_BIT]) |=> pend_syserr_ff[0])
		else $error("Single-bit system-error not queued"); // [R2] [R8]
	AST_GLOBAL_GATE: assert property (@(posedge clk_in) disable iff (srst_in)
		(ce_in && !syserr_global_en_in && pend_syserr_ff == '0) |=> pend_syserr_ff == '0)
		else $error("System-error queued while globally disabled"); // [R3]
	AST_LOCK_QUEUED: assert property (@(posedge clk_in) disable iff (srst_in)
		(ce_in && nondram_lock_in && !status_ff[LOCK_BIT] && syserr_global_en_in &&
		system_error_report_enable_ff[LOCK_BIT]) |=> pend_syserr_ff[2])
		else $error("Lock system-error not queued"); // [R6]
	AST_MULTI_QUEUED: assert property (@(posedge clk_in) disable iff (srst_in)
		(ce_in && multibit_ecc_in && !status_ff[MULTIBIT_BIT] &&
		mgmt_interrupt_report_enable_ff[MULTIBIT_BIT]) |=> pend_mgmt_ff[1])
		else $error("Multibit interrupt not queued"); // [R12]
	AST_MULTI_SYSERR: assert property (@(posedge clk_in) disable iff (srst_in)
		(ce_in && multibit_ecc_in && !status_ff[MULTIBIT_BIT] && syserr_global_en_in &&
		system_error_report_enable_ff[MULTIBIT_BIT]) |=> pend_syserr_ff[1])
		else $error("Multibit system-error not queued"); // [R7]
	AST_SINGLE_MGMT: assert property (@(posedge clk_in) disable iff (srst_in)
		(ce_in && singlebit_ecc_in && !status_ff[SINGLEBIT_BIT] &&
		mgmt_interrupt_report_enable_ff[SINGLEBIT_BIT]) |=> pend_mgmt_ff[0])
		else $error("Single-bit interrupt not queued"); // [R13]
	AST_THERMAL_MGMT: assert property (@(posedge clk_in) disable iff (srst_in)
		(ce_in && thermal_trip_in && !status_ff[THERMAL_BIT] &&
		mgmt_interrupt_report_enable_ff[THERMAL_BIT] &&
		!(system_error_report_enable_ff[THERMAL_BIT] && syserr_global_en_in)) |=> pend_mgmt_ff[3])
		else $error("Thermal interrupt not queued"); // [R10]
	AST_THERMAL_ONE: assert property (@(posedge clk_in) disable iff (srst_in)
		!(pend_syserr_ff[3] && pend_mgmt_ff[3] && $rose(pend_mgmt_ff[3])))
		else $error("Thermal trip queued two messages"); // [R11]
	AST_THERMAL_BLOCK: assert property (@(posedge clk_in) disable iff (srst_in || pwrgood_rst_in)
		(ce_in && status_ff[THERMAL_BIT] && !(status_clr_in && status_clr_data_in[THERMAL_BIT]))
		|=> status_ff[THERMAL_BIT] && !$rose(pend_mgmt_ff[3]) && !$rose(pend_syserr_ff[3]))
		else $error("Thermal message while flag set"); // [R17]
	AST_STICKY: assert property (@(posedge clk_in) disable iff (pwrgood_rst_in)
		(ce_in && status_ff[LOCK_BIT] && !status_clr_in) |=> status_ff[LOCK_BIT])
		else $error("Status flag dropped without clear"); // [R18]
	AST_RESERVED_ZERO: assert property (@(posedge clk_in) disable iff (srst_in)
		((system_error_report_enable_ff & ~SYSERR_EN_WMASK) == '0 &&
		(mgmt_interrupt_report_enable_ff & ~MGMT_EN_WMASK) == '0))
		else $error("Reserved enable bit set"); // [R15] [R16]
	AST_ONCE: assert property (@(posedge clk_in) disable iff (srst_in)
		(status_ff[SINGLEBIT_BIT] && !pend_syserr_ff[0]) |=> !pend_syserr_ff[0])
		else $error("Repeat message while flag stays set"); // [R19]

	COV_SYSERR: cover property (@(posedge clk_in) link_valid_out && link_kind_out == MSG_SYSERR);
	COV_MGMT: cover property (@(posedge clk_in) link_valid_out && link_kind_out == MSG_MGMT);
	COV_BOTH_PEND: cover property (@(posedge clk_in) (|pend_syserr_ff) && (|pend_mgmt_ff));
	COV_CLR_SET: cover property (@(posedge clk_in) status_clr_in && |rise);
endmodule : error_message_routing
`default_nettype wire

// *** hw/msg_req_if.sv ***
// Request handshake between event capture and the message sender
`timescale 1ns/10ps
`default_nettype none
interface msg_req_if;
	logic valid;
	logic ready;
	logic [1:0] kind;
	modport src (output valid, output kind, input ready);
	modport snk (input valid, input kind, output ready);
endinterface : msg_req_if
`default_nettype wire

// *** hw/msg_sender.sv ***
// Sends one queued message per request onto the downstream link
`timescale 1ns/10ps
`default_nettype none
module msg_sender
	import err_route_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	msg_req_if.snk req,
	output logic link_valid_out,
	output logic [1:0] link_kind_out,
	input wire logic link_ready_in
);
	logic busy_ff;
	logic nxt_busy;
	logic [1:0] kind_ff;
	logic [1:0] nxt_kind;

	assign req.ready = !busy_ff;
	assign link_valid_out = busy_ff;
	assign link_kind_out = kind_ff;

	always_comb
	begin
		nxt_busy = busy_ff;
		nxt_kind = kind_ff;
		if (busy_ff && link_ready_in)
		begin
			nxt_busy = 1'b0;
			nxt_kind = MSG_NONE;
		end
		else if (!busy_ff && req.valid)
		begin
			nxt_busy = 1'b1;
			nxt_kind = req.kind;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			busy_ff <= 1'b0;
			kind_ff <= MSG_NONE;
		end
		else if (ce_in)
		begin
			busy_ff <= nxt_busy;
			kind_ff <= nxt_kind;
		end
	end

	AST_KIND_HELD: assert property (@(posedge clk_in) disable iff (srst_in)
		(link_valid_out && !link_ready_in && ce_in) |=> $stable(link_kind_out) && link_valid_out)
		else $error("Link message changed before accept"); // [R1]
endmodule : msg_sender
`default_nettype wire

// *** verif/error_message_routing_test.sv ***
// Self-checking bench for the error message routing block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module error_message_routing_test
	import err_route_pkg::*;
;
	typedef struct packed {
		logic [15:0] sys;
		logic [15:0] mgmt;
		logic glob;
		logic [3:0] ev;
		logic [1:0] kind;
		logic [15:0] flags;
	} row_t;
	// Each row enables exactly one report type, as software must
	row_t rows [9] = '{
		'{16'h0001, 16'h0000, 1'b1, 4'h1, 2'h1, 16'h0001},
		'{16'h0000, 16'h0001, 1'b1, 4'h1, 2'h2, 16'h0001},
		'{16'h0002, 16'h0000, 1'b1, 4'h2, 2'h1, 16'h0002},
		'{16'h0000, 16'h0002, 1'b1, 4'h2, 2'h2, 16'h0002},
		'{16'h0200, 16'h0000, 1'b1, 4'h4, 2'h1, 16'h0200},
		'{16'h0800, 16'h0000, 1'b1, 4'h8, 2'h1, 16'h0800},
		'{16'h0000, 16'h0800, 1'b1, 4'h8, 2'h2, 16'h0800},
		'{16'h0001, 16'h0000, 1'b0, 4'h1, 2'h0, 16'h0001},
		'{16'h0000, 16'h0800, 1'b0, 4'h8, 2'h2, 16'h0800}};
	logic clk = 1'b0, srst = 1'b1, pgood = 1'b1, wr_s = 1'b0, rd_s = 1'b0, clr = 1'b0;
	logic glob = 1'b0, ce = 1'b1, lv, lr;
	logic [7:0] addr = 8'h00, cnt, got_n;
	logic [1:0] be = 2'h3, lk, last_k;
	logic [15:0] wd = 16'h0000, clr_d = 16'h0000, rdata, flags, v;
	logic [3:0] ev = 4'h0;
	int bad_count = 0, compares = 0;

	error_message_routing i_dut (.clk_in(clk), .srst_in(srst), .pwrgood_rst_in(pgood),
		.ce_in(ce), .cfg_wr_in(wr_s), .cfg_rd_in(rd_s), .cfg_addr_in(addr),
		.cfg_be_in(be), .cfg_wdata_in(wd), .cfg_rdata_out(rdata), .status_clr_in(clr),
		.status_clr_data_in(clr_d), .error_status_flags_out(flags),
		.syserr_global_en_in(glob), .thermal_trip_in(ev[3]), .nondram_lock_in(ev[2]),
		.multibit_ecc_in(ev[1]), .singlebit_ecc_in(ev[0]), .link_valid_out(lv),
		.link_kind_out(lk), .link_ready_in(lr));
	link_msg_receiver i_link (.clk_in(clk), .srst_in(srst), .link_valid_in(lv),
		.link_kind_in(lk), .link_ready_out(lr), .msg_cnt_out(cnt), .last_kind_out(last_k));

	initial
	begin
		forever #2 clk = ~clk;
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wd <= d;
		be <= b;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask : rd

	// Settling span covers two stalled messages plus idle gaps
	task automatic fire(input logic [3:0] e);
		logic [7:0] c0;
		c0 = cnt;
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= 4'h0;
		repeat (14) @(posedge clk);
		#1 got_n = cnt - c0;
	endtask : fire

	task automatic final_report;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	initial
	begin
		#80000;
		bad_count++;
		final_report();
	end

	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		pgood <= 1'b0;
		rd(8'hCA);
		`CHK(v, 16'h0000)
		rd(8'hCC);
		`CHK(v, 16'h0000)
		wr(8'hCA, 16'hFFFF, 2'h1);
		rd(8'hCA);
		`CHK(v, 16'h0003)
		wr(8'hCA, 16'hFFFF, 2'h3);
		rd(8'hCA);
		`CHK(v, 16'h0A03)
		wr(8'hCC, 16'hFFFF, 2'h3);
		rd(8'hCC);
		`CHK(v, 16'h0803)
		rd(8'hCE);
		`CHK(v, 16'h0000)
		foreach (rows[i])
		begin
			wr(8'hCA, rows[i].sys, 2'h3);
			wr(8'hCC, rows[i].mgmt, 2'h3);
			glob <= rows[i].glob;
			fire(rows[i].ev);
			`CHK(got_n, {7'h00, rows[i].kind != 2'h0})
			if (rows[i].kind != 2'h0)
				`CHK(last_k, rows[i].kind)
			`CHK(flags, rows[i].flags)
			@(posedge clk);
			clr <= 1'b1;
			clr_d <= 16'hFFFF;
			@(posedge clk);
			clr <= 1'b0;
			#1 `CHK(flags, 16'h0000)
		end
		// Both thermal enables on at once still yields a single message
		wr(8'hCA, 16'h0800, 2'h3);
		wr(8'hCC, 16'h0800, 2'h3);
		glob <= 1'b1;
		fire(4'h8);
		`CHK(got_n, 8'h01)
		fire(4'h8);
		`CHK(got_n, 8'h00)
		wr(8'hCA, 16'h0003, 2'h3);
		fire(4'h3);
		`CHK(got_n, 8'h02)
		fire(4'h1);
		`CHK(got_n, 8'h00)
		// Ordinary reset leaves the sticky flags alone
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		#1 `CHK(flags, 16'h0803)
		rd(8'hCA);
		`CHK(v, 16'h0000)
		@(posedge clk);
		pgood <= 1'b1;
		@(posedge clk);
		pgood <= 1'b0;
		#1 `CHK(flags, 16'h0000)
		// Clock enable low freezes the flags even when an error arrives
		@(posedge clk);
		ce <= 1'b0;
		fire(4'h1);
		`CHK(flags, 16'h0000)
		@(posedge clk);
		ce <= 1'b1;
		final_report();
	end
endmodule : error_message_routing_test
`default_nettype wire

// *** verif/link_msg_receiver.sv ***
// Downstream-link receiver model that accepts error messages after a stall
`timescale 1ns/10ps
`default_nettype none
module link_msg_receiver #(
	parameter int STALL = 2
)
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic link_valid_in,
	input wire logic [1:0] link_kind_in,
	output logic link_ready_out,
	output logic [7:0] msg_cnt_out,
	output logic [1:0] last_kind_out
);
	logic [3:0] wait_ff;

	// Stalls every message so the sender must hold it; counts each one taken
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			wait_ff <= 4'h0;
			link_ready_out <= 1'b0;
			msg_cnt_out <= 8'h00;
			last_kind_out <= 2'h0;
		end
		else
		begin
			if (!link_valid_in || link_ready_out)
				wait_ff <= 4'h0;
			else if (wait_ff != STALL[3:0])
				wait_ff <= wait_ff + 4'h1;
			link_ready_out <= link_valid_in && !link_ready_out && (wait_ff == STALL[3:0]);
			if (link_valid_in && link_ready_out)
			begin
				msg_cnt_out <= msg_cnt_out + 8'h01;
				last_kind_out <= link_kind_in;
			end
		end
	end
endmodule : link_msg_receiver
`default_nettype wire
